// *** config_defs.sv ***
// Shared constants of the global configuration bank and the strap synchroniser
package config_defs;
  localparam logic [15:0] index_port_low      = 16'h002E;
  localparam logic [15:0] index_port_high     = 16'h004E;
  localparam logic [7:0]  entry_key           = 8'h87;
  localparam logic [7:0]  exit_key            = 8'hAA;
  localparam logic [7:0]  blocked_read_value  = 8'hFF;
  localparam logic [7:0]  idx_software_reset  = 8'h02;
  localparam logic [7:0]  idx_device_select   = 8'h07;
  localparam logic [7:0]  idx_identity_high   = 8'h20;
  localparam logic [7:0]  idx_identity_low    = 8'h21;
  localparam logic [7:0]  idx_power_down      = 8'h22;
  localparam logic [7:0]  idx_port_power_down = 8'h23;
  localparam logic [7:0]  idx_global_option   = 8'h24;
  localparam logic [7:0]  idx_device_first    = 8'h30;
  localparam logic [7:0]  reset_device_select = 8'h00;
  localparam logic [7:0]  reset_power_down    = 8'hFF;
  localparam logic [7:0]  reset_port_power    = 8'hF0;
  localparam logic [7:0]  reset_global_option = 8'h40;
  localparam logic [7:0]  mask_power_down     = 8'h79;
  localparam logic [7:0]  mask_port_power     = 8'hF1;
  localparam logic [7:0]  mask_global_option  = 8'h5A;
  localparam int          bit_software_reset  = 0;
  localparam int          bit_floppy_ctrl     = 0;
  localparam int          bit_parallel        = 3;
  localparam int          bit_serial_a        = 4;
  localparam int          bit_serial_b        = 5;
  localparam int          bit_hw_monitor      = 6;
  localparam int          bit_immediate_pd    = 0;
  localparam int          bit_serial_c        = 4;
  localparam int          bit_clock_rate      = 6;
  localparam int          bit_system_fan      = 4;
  localparam int          bit_processor_fan   = 3;
  localparam int          bit_keyboard_strap  = 2;
  localparam int          bit_floppy_strap    = 1;
  localparam int          strap_count         = 4;
  localparam logic [2:0]  strap_settle_count  = 3'h4;
  // Arbitrary identity values
  localparam logic [7:0]  identity_high       = 8'h5C;
  localparam logic [3:0]  identity_low_family = 4'h1;
  localparam logic [3:0]  silicon_revision    = 4'h0;
endpackage

// *** pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level <= 1'b0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule

// *** global_config_register_bank.sv ***
// Global configuration register bank behind the index/data port pair
// Notes on behaviour
// R1: Index/data ports at 2E/2F or 4E/4F.
// R2: Host writes entry key twice first.
// R3: Device registers reach only selected device.
// R4: Index 07h selects device, resets 00h.
// R5: Index 02h write-only, bit0 software reset.
// R6: Index 20h returns fixed identity high.
// R7: Index 21h low byte carries revision.
// R8: Index 22h function power-downs, reset FFh.
// R9: Index 23h serial C-F power-downs, F0h.
// R10: Index 23h bit0 powers chip down now.
// R11: Some index 24h bits come from straps.
// R12: Index 24h bit6 clock rate, default one.
// R13: Index 24h bit4 system fan drive type.
// R14: Index 24h bit3 processor fan type.
// R15: Index 24h bit2 read-only keyboard strap.
// R16: Index 24h bit1 floppy enable from strap.
// R17: Lock bit blocks configuration reads, writes.
// R18: Reserved bits ignore writes, read zero except 22h bits 7,2,1 after reset.
// R19: Software reset restores non-strapped defaults.
`timescale 1ns/1ps
module global_config_register_bank (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] io_address,
  input  wire logic [7:0]  io_write_data,
  input  wire logic        io_write,
  input  wire logic        io_read,
  output logic [7:0]       io_read_data,
  output logic             io_read_valid,
  output logic             io_claim,
  input  wire logic        config_port_select_strap,
  input  wire logic        keyboard_ctrl_strap_pin,
  input  wire logic        floppy_disable_strap_pin,
  input  wire logic        config_access_lock,
  output logic             config_mode,
  output logic [7:0]       logical_device_number,
  output logic [7:0]       device_reg_index,
  output logic [7:0]       device_reg_write_data,
  output logic             device_reg_write,
  output logic             device_reg_read,
  input  wire logic [7:0]  device_reg_read_data,
  output logic             software_reset_pulse,
  output logic             hardware_monitor_enable,
  output logic             serial_port_a_enable,
  output logic             serial_port_b_enable,
  output logic             serial_port_c_enable,
  output logic             serial_port_d_enable,
  output logic             serial_port_e_enable,
  output logic             serial_port_f_enable,
  output logic             parallel_port_enable,
  output logic             floppy_controller_enable,
  output logic             immediate_power_down,
  output logic             input_clock_rate_select,
  output logic             system_fan_drive,
  output logic             processor_fan_drive,
  output logic             keyboard_ctrl_strap_enable,
  output logic             floppy_interface_enable
);
  import config_defs::*;

  typedef enum logic [1:0] {locked_out, key_seen, unlocked} entry_type;

  logic [strap_count-1:0] strap_pins;
  logic [strap_count-1:0] strap_levels;
  logic                   port_high;
  logic                   lock_level;
  logic                   port_select_level;
  logic                   keyboard_level;
  logic                   floppy_level;
  logic                   straps_loaded;
  logic [15:0]            index_port;
  logic [15:0]            data_port;
  logic                   at_index;
  logic                   at_data;
  logic                   access_ok;
  logic                   data_write;
  logic                   data_read;
  logic                   index_write;
  logic                   read_taken;
  logic [7:0]             index_reg;
  entry_type              entry_state;
  entry_type              next_entry_state;
  logic [7:0]             power_down;
  logic [7:0]             port_power;
  logic [7:0]             global_option;
  logic [7:0]             next_global_option;
  logic [7:0]             next_read_data;

  // Write mask of a global register; zero bits are reserved or read-only
  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    case (idx)
      idx_device_select:   write_mask = 8'hFF;
      idx_power_down:      write_mask = mask_power_down;
      idx_port_power_down: write_mask = mask_port_power;
      idx_global_option:   write_mask = mask_global_option;
      default:             write_mask = 8'h00;
    endcase
  endfunction

  // True for indices forwarded to the selected logical device
  function automatic logic is_device_reg(input logic [7:0] idx);
    is_device_reg = (idx >= idx_device_first);
  endfunction

  // True for a data-port write aimed at one global register
  function automatic logic global_write(input logic [7:0] idx);
    global_write = data_write && (index_reg == idx);
  endfunction

  assign strap_pins = {config_access_lock, floppy_disable_strap_pin,
                       keyboard_ctrl_strap_pin, config_port_select_strap};

  // Every pin input passes the three-stage synchroniser
  generate
    for (genvar i = 0; i < strap_count; i++) begin : g_sync
      pin_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    (strap_pins[i]),
        .level  (strap_levels[i])
      );
    end
  endgenerate

  // Settled strap levels by function
  assign port_select_level = strap_levels[0];
  assign keyboard_level    = strap_levels[1];
  assign floppy_level      = strap_levels[2];
  assign lock_level        = strap_levels[3];

  // Port select strap caught once after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_high <= 1'b0;
    end else if (!straps_loaded) begin
      port_high <= port_select_level; // R1
    end
  end

  // Counts edges until the synchroniser shows settled strap levels
  logic [2:0] settle_count;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_count <= 3'h0;
    end else if (!straps_loaded) begin
      settle_count <= settle_count + 3'h1;
    end
  end

  // Straps stop loading one edge after the levels are valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      straps_loaded <= 1'b0;
    end else if (settle_count == strap_settle_count) begin
      straps_loaded <= 1'b1; // R11
    end
  end

  assign index_port = port_high ? index_port_high : index_port_low; // R1
  assign data_port  = index_port + 16'h0001; // R1
  assign at_index   = (io_address == index_port);
  assign at_data    = (io_address == data_port);
  assign io_claim   = at_index || (at_data && config_mode);
  assign config_mode = (entry_state == unlocked);
  assign access_ok  = config_mode && !lock_level; // R17
  assign data_write = io_write && at_data && access_ok;
  assign data_read  = io_read && at_data && access_ok;
  assign index_write = io_write && at_index;
  assign read_taken  = io_read && io_claim;

  // Entry key sequence on the index port
  always_comb begin
    next_entry_state = entry_state;
    if (index_write && straps_loaded) begin
      case (entry_state)
        locked_out: begin
          if (io_write_data == entry_key) begin
            next_entry_state = key_seen; // R2
          end
        end
        key_seen: begin
          if (io_write_data == entry_key) begin
            next_entry_state = unlocked; // R2
          end else begin
            next_entry_state = locked_out;
          end
        end
        unlocked: begin
          if (io_write_data == exit_key) begin
            next_entry_state = locked_out;
          end
        end
        default: next_entry_state = locked_out;
      endcase
    end
  end

  // Entry state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_state <= locked_out;
    end else begin
      entry_state <= next_entry_state;
    end
  end

  // Index register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      index_reg <= 8'h00;
    end else if (index_write && config_mode) begin
      index_reg <= io_write_data;
    end
  end

  // Software reset pulse; the bit never holds its value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      software_reset_pulse <= 1'b0;
    end else begin
      software_reset_pulse <= global_write(idx_software_reset) &&
        io_write_data[bit_software_reset]; // R5 R19
    end
  end

  // Logical device select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      logical_device_number <= reset_device_select; // R4
    end else if (software_reset_pulse) begin
      logical_device_number <= reset_device_select; // R19
    end else if (global_write(idx_device_select)) begin
      logical_device_number <= io_write_data; // R4
    end
  end

  // Function power-down register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_down <= reset_power_down; // R8
    end else if (software_reset_pulse) begin
      power_down <= reset_power_down; // R19
    end else if (global_write(idx_power_down)) begin
      power_down <= io_write_data & write_mask(idx_power_down); // R8 R18
    end
  end

  // Serial port and immediate power-down register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_power <= reset_port_power; // R9
    end else if (software_reset_pulse) begin
      port_power <= reset_port_power; // R19
    end else if (global_write(idx_port_power_down)) begin
      port_power <= io_write_data & write_mask(idx_port_power_down); // R9 R18
    end
  end

  // Writable option bits merged over the read-only strap bit
  assign next_global_option =
    (global_option & ~write_mask(idx_global_option)) |
    (io_write_data & write_mask(idx_global_option));

  // Global option register; strap bits load once after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_option <= reset_global_option; // R12
    end else if (!straps_loaded) begin
      global_option[bit_keyboard_strap] <= keyboard_level; // R11 R15
      global_option[bit_floppy_strap]   <= floppy_level; // R11 R16
    end else if (software_reset_pulse) begin
      global_option[bit_clock_rate]    <= reset_global_option[bit_clock_rate];
      global_option[bit_system_fan]    <= 1'b0; // R19
      global_option[bit_processor_fan] <= 1'b0; // R19
    end else if (global_write(idx_global_option)) begin
      global_option <= next_global_option; // R13 R14 R16 R18
    end
  end

  // Accesses to logical device registers
  assign device_reg_index      = index_reg;
  assign device_reg_write_data = io_write_data;
  assign device_reg_write = data_write && is_device_reg(index_reg); // R3
  assign device_reg_read  = data_read && is_device_reg(index_reg); // R3

  // Read data selection
  always_comb begin
    next_read_data = 8'h00; // R18
    if (!access_ok) begin
      next_read_data = blocked_read_value; // R17
    end else if (at_index) begin
      next_read_data = index_reg;
    end else if (is_device_reg(index_reg)) begin
      next_read_data = device_reg_read_data; // R3
    end else begin
      case (index_reg)
        idx_identity_high: next_read_data = identity_high; // R6
        idx_identity_low:
          next_read_data = {identity_low_family, silicon_revision}; // R7
        idx_device_select:   next_read_data = logical_device_number;
        idx_power_down:      next_read_data = power_down;
        idx_port_power_down: next_read_data = port_power;
        idx_global_option:   next_read_data = global_option; // R15
        default:             next_read_data = 8'h00; // R5 R18
      endcase
    end
  end

  // Read answer strobe, one cycle after a claimed read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_read_valid <= 1'b0;
    end else begin
      io_read_valid <= read_taken;
    end
  end

  // Read data holds until the next claimed read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_read_data <= 8'h00;
    end else if (read_taken) begin
      io_read_data <= next_read_data;
    end
  end

  // Register fields drive the chip functions
  assign hardware_monitor_enable    = power_down[bit_hw_monitor]; // R8
  assign serial_port_b_enable       = power_down[bit_serial_b]; // R8
  assign serial_port_a_enable       = power_down[bit_serial_a]; // R8
  assign parallel_port_enable       = power_down[bit_parallel]; // R8
  assign floppy_controller_enable   = power_down[bit_floppy_ctrl]; // R8
  // Upper serial ports and whole-chip power-down
  assign serial_port_c_enable       = port_power[bit_serial_c]; // R9
  assign serial_port_d_enable       = port_power[bit_serial_c+1]; // R9
  assign serial_port_e_enable       = port_power[bit_serial_c+2]; // R9
  assign serial_port_f_enable       = port_power[bit_serial_c+3]; // R9
  assign immediate_power_down       = port_power[bit_immediate_pd]; // R10
  // Global option fields
  assign input_clock_rate_select    = global_option[bit_clock_rate]; // R12
  assign system_fan_drive           = global_option[bit_system_fan]; // R13
  assign processor_fan_drive        = global_option[bit_processor_fan]; // R14
  assign keyboard_ctrl_strap_enable = global_option[bit_keyboard_strap]; // R15
  assign floppy_interface_enable    = !global_option[bit_floppy_strap]; // R16
endmodule

// *** cfg_bank_sva.sv ***
// Concurrent checks on the global configuration bank ports
`timescale 1ns/1ps
module cfg_bank_sva
  import config_defs::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [15:0] io_address,
  input wire logic [7:0]  io_write_data,
  input wire logic        io_write,
  input wire logic        io_read,
  input wire logic [7:0]  io_read_data,
  input wire logic        io_read_valid,
  input wire logic        io_claim,
  input wire logic        config_mode,
  input wire logic [7:0]  logical_device_number,
  input wire logic [7:0]  device_reg_index,
  input wire logic [7:0]  device_reg_write_data,
  input wire logic        device_reg_write,
  input wire logic        device_reg_read,
  input wire logic        software_reset_pulse,
  input wire logic        hardware_monitor_enable,
  input wire logic        floppy_controller_enable,
  input wire logic        immediate_power_down,
  input wire logic        input_clock_rate_select,
  input wire logic        system_fan_drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sw_defaults;
    !software_reset_pulse && logical_device_number == reset_device_select
      && hardware_monitor_enable && floppy_controller_enable
      && !immediate_power_down && input_clock_rate_select && !system_fan_drive;
  endsequence
  chk_rd_answer:
  assert property (io_read && io_claim |=> io_read_valid)
    else $error("read answer missing");
  chk_dev_write:
  assert property (device_reg_write |-> io_write && config_mode
    && io_address[0] && device_reg_index >= idx_device_first
    && device_reg_write_data == io_write_data)
    else $error("device write strobe without cause");
  chk_dev_read:
  assert property (device_reg_read |-> io_read && config_mode
    && io_address[0] && device_reg_index >= idx_device_first)
    else $error("device read strobe without cause");
  chk_ldn_write:
  assert property ($changed(logical_device_number) |->
    $past(software_reset_pulse) || $past(io_write && config_mode
    && io_address[0] && device_reg_index == idx_device_select))
    else $error("device number changed without write");
  chk_sw_pulse:
  assert property (software_reset_pulse |->
    $past(io_write && io_write_data[0] && io_address[0]))
    else $error("software reset pulse without write");
  chk_id_high:
  assert property (io_read_valid && $past(io_address[0]
    && device_reg_index == idx_identity_high) |->
    io_read_data == identity_high || io_read_data == blocked_read_value)
    else $error("identity high byte wrong");
  chk_ipd_now:
  assert property ($changed(immediate_power_down) |->
    $past(software_reset_pulse) || ($past(io_write && config_mode
    && device_reg_index == idx_port_power_down)
    && $past(io_write_data[0]) == immediate_power_down))
    else $error("power-down bit changed without write");
  chk_rsvd_zero:
  assert property (io_read_valid && $past(io_address[0]
    && device_reg_index == idx_power_down) |->
    (io_read_data & ~mask_power_down) == 8'h00
    || io_read_data == blocked_read_value)
    else $error("reserved bits read nonzero");
  chk_sw_defaults:
  assert property (software_reset_pulse |=> sw_defaults)
    else $error("defaults not restored after software reset");
endmodule

// *** host_model.sv ***
// Host model driving the configuration index and data ports
`timescale 1ns/1ps
module host_model
  import config_defs::*;
(
  input  wire logic        clk,
  input  wire logic        config_port_select_strap,
  output logic [15:0]      io_address,
  output logic [7:0]       io_write_data,
  output logic             io_write,
  output logic             io_read,
  input  wire logic [7:0]  io_read_data,
  input  wire logic        io_read_valid
);
  logic [15:0] port;
  assign port = config_port_select_strap ? index_port_high
                                         : index_port_low;
  initial begin
    io_address = 16'h0000;
    io_write_data = 8'h00;
    io_write = 1'b0;
    io_read = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk) #5;
    io_address = a;
    io_write_data = x;
    io_write = 1'b1;
    @(posedge clk) #5;
    io_write = 1'b0;
    io_address = ~a;
    io_write_data = ~x;
  endtask
  task automatic getr(input logic [7:0] i, output logic [7:0] x,
                      output logic ok);
    wr(port, i);
    @(posedge clk) #5;
    io_address = port + 16'h0001;
    io_read = 1'b1;
    @(posedge clk) #5;
    io_read = 1'b0;
    io_address = ~io_address;
    ok = io_read_valid;
    x = io_read_data;
  endtask
  task automatic setr(input logic [7:0] i, x);
    wr(port, i);
    wr(port + 16'h0001, x);
  endtask
  task automatic enter();
    wr(port, entry_key);
    wr(port, entry_key);
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench of the global configuration register bank
`timescale 1ns/1ps
module tb_top;
  import config_defs::*;
  logic        clk, resetn, config_port_select_strap, config_access_lock;
  logic        keyboard_ctrl_strap_pin, floppy_disable_strap_pin;
  logic [15:0] io_address;
  logic [7:0]  io_write_data, io_read_data, device_reg_read_data;
  logic        io_write, io_read, io_read_valid, io_claim, config_mode;
  logic [7:0]  logical_device_number, device_reg_index, device_reg_write_data;
  logic        device_reg_write, device_reg_read, software_reset_pulse;
  logic        hardware_monitor_enable, serial_port_a_enable;
  logic        serial_port_b_enable, serial_port_c_enable;
  logic        serial_port_d_enable, serial_port_e_enable;
  logic        serial_port_f_enable, parallel_port_enable;
  logic        floppy_controller_enable, immediate_power_down;
  logic        input_clock_rate_select, system_fan_drive;
  logic        processor_fan_drive, keyboard_ctrl_strap_enable;
  logic        floppy_interface_enable, v;
  logic [7:0]  r07, r22, r23, r24, d, w;
  logic [15:0] dw;
  logic [7:0]  dr;
  logic [22:0] obs;
  logic [31:0] seed;
  int          miscompares, cmp_count, cyc;
  global_config_register_bank i_dut (.*);
  host_model i_host (.*);
  always @(posedge clk) begin
    if (device_reg_write) dw <= {device_reg_index, device_reg_write_data};
    if (device_reg_read) dr <= device_reg_index;
  end
  assign obs = {logical_device_number, hardware_monitor_enable,
    serial_port_b_enable, serial_port_a_enable, parallel_port_enable,
    floppy_controller_enable, serial_port_f_enable, serial_port_e_enable,
    serial_port_d_enable, serial_port_c_enable, immediate_power_down,
    input_clock_rate_select, system_fan_drive, processor_fan_drive,
    keyboard_ctrl_strap_enable, floppy_interface_enable};
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [22:0] exp_outs();
    return {r07, r22[6:3], r22[0], r23[7:4], r23[0], r24[6], r24[4:2],
            ~r24[1]};
  endfunction
  function automatic logic [7:0] masked(input logic [7:0] i, x);
    case (i)
      idx_power_down:      return x & mask_power_down;
      idx_port_power_down: return x & mask_port_power;
      idx_global_option:   return x & mask_global_option
                             | {5'h00, keyboard_ctrl_strap_pin, 2'b00};
      default:             return x;
    endcase
  endfunction
  task automatic chk(input logic [22:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] i, e);
    i_host.getr(i, d, v);
    chk({14'h0000, v, d}, {15'h0001, e});
  endtask
  task automatic put(input logic [7:0] i, x);
    i_host.setr(i, x);
    if (!config_access_lock) case (i)
      idx_device_select:   r07 = x;
      idx_power_down:      r22 = masked(i, x);
      idx_port_power_down: r23 = masked(i, x);
      idx_global_option:   r24 = masked(i, x);
      default: ;
    endcase
  endtask
  task automatic defaults(input logic [7:0] s24);
    r07 = reset_device_select;
    r22 = reset_power_down;
    r23 = reset_port_power;
    r24 = reset_global_option | s24;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    resetn = 1'b0;
    config_access_lock = 1'b0;
    device_reg_read_data = 8'h00;
    seed = 32'hace0_48c3;
    for (int s = 0; s < 2; s++) begin
      seed = lfsr(seed);
      resetn = 1'b0;
      config_port_select_strap = s[0];
      keyboard_ctrl_strap_pin = seed[3];
      floppy_disable_strap_pin = seed[7];
      repeat (3) @(posedge clk);
      #5 resetn = 1'b1;
      repeat (8) @(posedge clk);
      #5;
      defaults({5'h00, keyboard_ctrl_strap_pin, floppy_disable_strap_pin, 1'b0});
      chk(obs, exp_outs());
      i_host.wr(i_host.port ^ 16'h0060, entry_key);
      i_host.wr(i_host.port ^ 16'h0060, entry_key);
      chk(config_mode, 1'b0);
      i_host.enter();
      chk(config_mode, 1'b1);
      rd_chk(idx_global_option, r24);
      put(idx_identity_high, seed[7:0]);
      rd_chk(idx_identity_high, identity_high);
      rd_chk(idx_identity_low, {identity_low_family, silicon_revision});
      for (int k = 0; k < 12; k++) begin
        seed = lfsr(seed);
        w = k < 4 ? 8'h00 : k < 8 ? 8'hff : seed[7:0];
        d = k % 4 == 0 ? idx_device_select : idx_identity_low + 8'(k % 4);
        put(d, w);
        chk(obs, exp_outs());
        rd_chk(d, masked(d, w));
      end
      config_access_lock = 1'b1;
      repeat (6) @(posedge clk);
      put(idx_power_down, 8'h00);
      rd_chk(idx_power_down, blocked_read_value);
      chk(obs, exp_outs());
      config_access_lock = 1'b0;
      repeat (6) @(posedge clk);
      #5 device_reg_read_data = seed[15:8];
      put(idx_device_first, seed[7:0]);
      rd_chk(idx_device_first, seed[15:8]);
      chk(dw, {idx_device_first, seed[7:0]});
      chk(dr, idx_device_first);
      put(idx_software_reset, 8'h01);
      @(posedge clk) #5;
      defaults(r24 & 8'h06);
      chk(obs, exp_outs());
      i_host.wr(i_host.port, exit_key);
      chk(config_mode, 1'b0);
      i_host.setr(idx_device_select, 8'h5a);
      i_host.enter();
      rd_chk(idx_device_select, r07);
    end
    finish_test();
  end
endmodule
bind global_config_register_bank cfg_bank_sva u_sva (.*);
